// ### bench/scp_console.sv
// console model on the far end of the serial line
// assumes the bench sets frame length and bit time before each character
`timescale 1ns/10ps
`default_nettype none
module scp_console (
  // clock
  input wire logic clk,
  // line
  input wire logic txd,
  output var logic rxd,
  output wire logic cts_n,
  // set by the bench
  input wire logic hold,
  input wire logic [3:0] nbits,
  input wire logic [15:0] bitc
);
  logic [11:0] q[$];
  logic [11:0] f;
  assign cts_n = hold;
  initial rxd = 1'b1;
  // centre sampling keeps clear of the edges where txd moves
  initial begin
    forever begin
      @(negedge txd);
      repeat (bitc / 2) @(posedge clk);
      f = 12'hFFF;
      f[0] = txd;
      for (int i = 1; i < nbits; i++) begin
        repeat (bitc) @(posedge clk);
        f[i] = txd;
      end
      q.push_back(f);
    end
  end
  // 8 data bits, no parity, one stop
  task automatic send(input logic [7:0] v);
    logic [9:0] w;
    w = {1'b1, v, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd <= w[i];
      repeat (bitc) @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

// ### bench/scp_uart_bench.sv
// self-checking bench for scp_uart with a console model on the line
// assumes scp_console.sv and scp_uart_chk.sv are compiled before it
`timescale 1ns/10ps
`default_nettype none
`include "scp_defs.vh"
module scp_uart_bench;
  logic clk, rst, psel, penable, pwrite, hold, pready, pslverr, txd, rxd, rts_n, cts_n, err;
  logic [7:0] paddr, b;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] access_mode;
  logic [3:0] nb;
  logic [15:0] bc;
  logic [10:0] cur;
  logic [10:0] cfg [2] = '{11'h2E7, 11'h50F};
  logic [31:0] seed = 32'h0000_0053;
  logic [31:0] z0 = 32'h0000_0000;
  int failures = 0, n_checks = 0, cyc = 0;
  scp_uart u_scp_uart (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .txd(txd), .rxd(rxd), .rts_n(rts_n), .cts_n(cts_n), .access_mode(access_mode));
  scp_console u_scp_console (.clk(clk), .txd(txd), .rxd(rxd), .cts_n(cts_n), .hold(hold),
    .nbits(nb), .bitc(bc));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      failures = failures + 1;
      close_out();
    end
  end
  function automatic logic [7:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  function automatic logic [3:0] nbits(input logic [10:0] c);
    return 4'h9 + 4'(c[3]) + 4'(c[5:4] != 2'h0) + 4'(c[6]);
  endfunction
  function automatic logic [15:0] blen(input logic [2:0] r);
    return 16'(`SCP_OVS * `SCP_TICKS(`SCP_B0 << r));
  endfunction
  function automatic logic [11:0] efr(input logic [10:0] c, input logic [7:0] v);
    logic [11:0] f;
    logic [7:0] m;
    m = c[3] ? v : {1'b0, v[6:0]};
    f = 12'hFFE;
    for (int i = 0; i < 8; i++) if (i < 7 || c[3]) f[i + 1] = v[i];
    if (c[5:4] != 2'h0) f[c[3] ? 9 : 8] = (c[5:4] == 2'h1) ? ~^m : ^m;
    return f;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // apb master; request held until the rising edge that sees pready, answer taken there
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic push(input logic [7:0] v);
    apb(1'b1, `SCP_OFS_TXD, {24'h00_0000, v});
  endtask
  task automatic getf(input logic [7:0] v);
    for (int k = 0; k < 20 * bc && u_scp_console.q.size() == 0; k++) @(posedge clk);
    chk("frame", 32'(efr(cur, v)), 32'(u_scp_console.q.pop_front()));
  endtask
  task automatic setc(input logic [10:0] c);
    apb(1'b1, `SCP_OFS_CFG, 32'(c));
    apb(1'b1, `SCP_OFS_CTRL, 32'h0000_0001);
    apb(1'b0, `SCP_OFS_ACT, z0);
    chk("act", 32'(c), rd);
    chk("mode", 32'(c[10:9]), 32'(access_mode));
    cur = c;
    nb <= nbits(c);
    bc <= blen(c[2:0]);
  endtask
  task automatic close_out();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = z0;
    hold = 1'b0;
    cur = `SCP_CFG_RST;
    nb = nbits(cur);
    bc = blen(cur[2:0]);
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, `SCP_OFS_CFG, z0);
    chk("cfg", 32'(`SCP_CFG_RST), rd);
    chk("mode", z0, 32'(access_mode));
    apb(1'b0, 8'h20, z0);
    chk("unmapped", 32'h0000_0001, 32'(err));
    apb(1'b1, `SCP_OFS_CFG, 32'h0000_0407);
    apb(1'b0, `SCP_OFS_ACT, z0);
    chk("act unsaved", 32'(`SCP_CFG_RST), rd);
    apb(1'b1, `SCP_OFS_CTRL, 32'h0000_0001);
    apb(1'b0, `SCP_OFS_STAT, z0);
    chk("save err", 32'h0000_0004, rd & 32'h0000_0004);
    apb(1'b0, `SCP_OFS_ACT, z0);
    chk("act kept", 32'(`SCP_CFG_RST), rd);
    apb(1'b1, `SCP_OFS_CTRL, 32'h0000_0002);
    apb(1'b0, `SCP_OFS_STAT, z0);
    chk("save err clr", z0, rd & 32'h0000_0004);
    b = xs();
    push(b);
    getf(b);
    foreach (cfg[i]) begin
      setc(cfg[i]);
      b = xs();
      push(b);
      getf(b);
      if (cfg[i][`SCP_F_FLOW] == `SCP_FLOW_HW) begin
        hold <= 1'b1;
        for (int k = 0; k < 16; k++) push(8'(k * 17));
        apb(1'b0, `SCP_OFS_STAT, z0);
        chk("fifo room", z0, rd & 32'h0000_0001);
        repeat (12 * bc) @(posedge clk);
        chk("held", z0, 32'(u_scp_console.q.size()));
        hold <= 1'b0;
        for (int k = 0; k < 16; k++) getf(8'(k * 17));
      end else begin
        u_scp_console.send(`SCP_XOFF);
        push(8'h5A);
        repeat (3 * bc) @(posedge clk);
        chk("paused", z0, 32'(u_scp_console.q.size()));
        apb(1'b0, `SCP_OFS_STAT, z0);
        chk("paused flag", 32'h0000_0008, rd & 32'h0000_0008);
        u_scp_console.send(`SCP_XON);
        getf(8'h5A);
        b = xs() | 8'h80;
        u_scp_console.send(b);
        apb(1'b0, `SCP_OFS_STAT, z0);
        chk("rx ready", 32'h0000_0002, rd & 32'h0000_000A);
        chk("rts", z0, 32'(rts_n));
        apb(1'b0, `SCP_OFS_RXD, z0);
        chk("rx data", 32'(b), rd);
        apb(1'b0, `SCP_OFS_STAT, z0);
        chk("rx taken", z0, rd & 32'h0000_0002);
      end
    end
    close_out();
  end
endmodule
`default_nettype wire

// ### bench/scp_uart_chk.sv
// assertion checker for scp_uart, watching only its ports
// assumes the map of scp_defs.vh; attached by the bind at the foot
`timescale 1ns/10ps
`default_nettype none
`include "scp_defs.vh"
module scp_uart_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // line and policy
  input wire logic txd,
  input wire logic rxd,
  input wire logic rts_n,
  input wire logic cts_n,
  input wire logic [1:0] access_mode
);
  // ------------
  // shadow of the saved settings
  // ------------
  logic [10:0] pend_q, act_q;
  logic prev_q;
  int run_q, cts_q, bit_c, low_max, frm;
  wire logic wr = psel && penable && pready && pwrite;
  wire logic save = wr && paddr == `SCP_OFS_CTRL && pwdata[`SCP_CTRL_SAVE];
  // too fast without flow control: save refused
  wire logic bad = pend_q[`SCP_F_FLOW] == `SCP_FLOW_NONE
    && pend_q[`SCP_F_BAUD] > `SCP_BAUD_MAX_NOFLOW;
  wire logic ok_save = save && !bad;
  wire logic hw = act_q[`SCP_F_FLOW] == `SCP_FLOW_HW;
  // only valid while the line is idle across a save
  always_comb begin
    bit_c = `SCP_OVS * `SCP_TICKS(`SCP_B0 << act_q[`SCP_F_BAUD]);
    low_max = bit_c * (8 + act_q[`SCP_F_DATA8] + (act_q[`SCP_F_PAR] != 2'h0));
    frm = low_max + bit_c * (1 + act_q[`SCP_F_STOP2]);
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend_q <= `SCP_CFG_RST;
      act_q <= `SCP_CFG_RST;
      prev_q <= 1'b1;
      run_q <= 0;
      cts_q <= 0;
    end else begin
      if (wr && paddr == `SCP_OFS_CFG) begin
        pend_q <= pwdata[`SCP_CFG_W-1:0];
      end
      if (ok_save) begin
        act_q <= pend_q;
      end
      prev_q <= txd;
      run_q <= (txd != prev_q) ? 1 : run_q + 1;
      cts_q <= cts_n ? cts_q + 1 : 0;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_access_follows: assert property (access_mode == act_q[`SCP_F_ACC])
    else $error("access mode differs from saved setting");
  a_save_only: assert property (!$stable(access_mode) |-> $past(ok_save))
    else $error("access mode moved without a save");
  a_illegal_kept: assert property (save && bad |=> $stable(access_mode))
    else $error("refused save still applied");
  a_cts_gate: assert property (hw && cts_q > frm |-> txd)
    else $error("character sent while cts held off");
  a_low_whole: assert property (txd && !prev_q |-> run_q % bit_c == 0)
    else $error("low run not whole bits");
  a_low_bound: assert property (txd && !prev_q |-> run_q <= low_max)
    else $error("low run longer than a character");
  a_rts_hw: assert property (rts_n |-> hw || $past(hw))
    else $error("rts raised outside hardware flow");
  a_reset_idle: assert property ($fell(rst) |-> txd && access_mode == 2'h0)
    else $error("not idle and shared after reset");
  c_save: cover property (ok_save);
  c_refused: cover property (save && bad);
  c_stall: cover property (hw && cts_q == frm);
endmodule
bind scp_uart scp_uart_chk u_scp_uart_chk (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .txd(txd), .rxd(rxd), .rts_n(rts_n), .cts_n(cts_n),
  .access_mode(access_mode));
`default_nettype wire

// ### core/scp_defs.vh
// constants for the serial console port: offsets, fields, resets, timing
// assumes a 10 MHz system clock and an apb master on the register side
`ifndef SCP_DEFS_VH
`define SCP_DEFS_VH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SCP_CLK_HZ 10000000
`define SCP_OVS 16
`define SCP_TICKS(b) (`SCP_CLK_HZ / (`SCP_OVS * (b)))
`define SCP_B0 300
`define SCP_B1 600
`define SCP_B2 1200
`define SCP_B3 2400
`define SCP_B4 4800
`define SCP_B5 9600
`define SCP_B6 19200
`define SCP_B7 38400
// clocks per oversample tick, clk / (16 * baud) rounded down
`define SCP_DIV0 12'h823
`define SCP_DIV1 12'h411
`define SCP_DIV2 12'h208
`define SCP_DIV3 12'h104
`define SCP_DIV4 12'h082
`define SCP_DIV5 12'h041
`define SCP_DIV6 12'h020
`define SCP_DIV7 12'h010
`define SCP_BAUD_MAX_NOFLOW 3'h5

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define SCP_OFS_CFG 8'h00
`define SCP_OFS_CTRL 8'h04
`define SCP_OFS_ACT 8'h08
`define SCP_OFS_STAT 8'h0C
`define SCP_OFS_TXD 8'h10
`define SCP_OFS_RXD 8'h14

// ----------------------------------------------------------------
// config fields, same layout in cfg and act
// ----------------------------------------------------------------
`define SCP_F_BAUD 2:0
`define SCP_F_DATA8 3
`define SCP_F_PAR 5:4
`define SCP_F_STOP2 6
`define SCP_F_FLOW 8:7
`define SCP_F_ACC 10:9
`define SCP_CFG_W 11
`define SCP_CFG_RST 11'h01D
`define SCP_PAR_NONE 2'h0
`define SCP_PAR_ODD 2'h1
`define SCP_PAR_EVEN 2'h2
`define SCP_FLOW_NONE 2'h0
`define SCP_FLOW_HW 2'h1
`define SCP_FLOW_XON 2'h2
`define SCP_CTRL_SAVE 0
`define SCP_CTRL_CLR 1
`define SCP_XOFF 8'h13
`define SCP_XON 8'h11

`endif

// ### core/scp_uart.v
// serial console port: apb registers, tx fifo, transmitter and receiver
// assumes rxd and cts_n are already synchronous to clk
//
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "scp_defs.vh"

// ----------------------------------------------------------------
// fifo
// ----------------------------------------------------------------
module scp_fifo #(
  parameter W = 8,
  parameter D = 16,
  parameter AW = 4
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // fill side
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  // drain side
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  localparam [AW:0] FULL = D[AW:0];
  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wp_q;
  reg [AW-1:0] rp_q;
  reg [AW:0] cnt_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = cnt_q != FULL;
  assign out_valid = cnt_q != {(AW+1){1'b0}};
  assign out_data = mem[rp_q];

  always @(posedge clk) begin
    if (push) mem[wp_q] <= in_data;
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wp_q <= {AW{1'b0}};
      rp_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) wp_q <= wp_q + 1'b1;
      if (pop) rp_q <= rp_q + 1'b1;
      if (push && !pop) cnt_q <= cnt_q + 1'b1;
      else if (pop && !push) cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule

// ----------------------------------------------------------------
// top
// ----------------------------------------------------------------
module scp_uart (
  // clock and reset
  input wire clk,
  input wire rst,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // serial line
  output reg txd,
  input wire rxd,
  output reg rts_n,
  input wire cts_n,
  // access policy for the session layer
  output wire [1:0] access_mode
);
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_START = 3'h1;
  localparam [2:0] S_DATA = 3'h2;
  localparam [2:0] S_PAR = 3'h3;
  localparam [2:0] S_STOP = 3'h4;

  reg [`SCP_CFG_W-1:0] cfg_q;
  reg [`SCP_CFG_W-1:0] act_q;
  reg save_err_q, par_err_q, frm_err_q, ovr_err_q, paused_q;
  reg [11:0] tick_cnt_q;
  reg [11:0] div;
  reg [2:0] tx_st_q, rx_st_q;
  reg [3:0] tx_sub_q, rx_sub_q;
  reg [2:0] tx_bit_q, rx_bit_q;
  reg [7:0] tx_sh_q, rx_sh_q, rx_data_q;
  reg tx_par_q, rx_par_q, tx_stop2_q, rx_full_q;
  reg [31:0] rd_d;

  wire [2:0] baud = act_q[`SCP_F_BAUD];
  wire data8 = act_q[`SCP_F_DATA8];
  wire [1:0] par = act_q[`SCP_F_PAR];
  wire [1:0] flow = act_q[`SCP_F_FLOW];
  assign access_mode = act_q[`SCP_F_ACC];

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire acc = psel && penable;
  wire hit = paddr == `SCP_OFS_CFG || paddr == `SCP_OFS_CTRL || paddr == `SCP_OFS_ACT ||
    paddr == `SCP_OFS_STAT || paddr == `SCP_OFS_TXD || paddr == `SCP_OFS_RXD;
  wire fifo_in_ready;
  // full fifo stalls the master rather than dropping the byte
  assign pready = !(acc && pwrite && paddr == `SCP_OFS_TXD && !fifo_in_ready);
  assign pslverr = acc && !hit;
  wire wr = acc && pwrite && pready && hit;
  wire rd = acc && !pwrite && hit;
  wire wr_ctrl = wr && paddr == `SCP_OFS_CTRL;
  wire save = wr_ctrl && pwdata[`SCP_CTRL_SAVE];
  wire clr = wr_ctrl && pwdata[`SCP_CTRL_CLR];
  wire cfg_ok = cfg_q[`SCP_F_FLOW] != `SCP_FLOW_NONE ||
    cfg_q[`SCP_F_BAUD] <= `SCP_BAUD_MAX_NOFLOW;

  always @* begin
    rd_d = 32'h0000_0000;
    case (paddr)
      `SCP_OFS_CFG: rd_d[`SCP_CFG_W-1:0] = cfg_q;
      `SCP_OFS_ACT: rd_d[`SCP_CFG_W-1:0] = act_q;
      `SCP_OFS_STAT: rd_d[7:0] = {tx_st_q != S_IDLE, ovr_err_q, frm_err_q, par_err_q,
        paused_q, save_err_q, rx_full_q, fifo_in_ready};
      `SCP_OFS_RXD: rd_d[7:0] = rx_data_q;
      default: rd_d = 32'h0000_0000;
    endcase
  end

  // read data latched in the setup cycle, valid throughout access
  always @(posedge clk or posedge rst) begin
    if (rst) prdata <= 32'h0000_0000;
    else if (psel && !penable) prdata <= rd_d;
  end

  // ----------------------------------------------------------------
  // configuration
  // ----------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_q <= `SCP_CFG_RST;
      act_q <= `SCP_CFG_RST;
      save_err_q <= 1'b0;
    end else begin
      if (wr && paddr == `SCP_OFS_CFG) cfg_q <= pwdata[`SCP_CFG_W-1:0];
      if (save && cfg_ok) act_q <= cfg_q;
      if (save && !cfg_ok) save_err_q <= 1'b1;
      else if (clr) save_err_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // oversampling tick
  // ----------------------------------------------------------------
  always @* begin
    case (baud)
      3'h0: div = `SCP_DIV0;
      3'h1: div = `SCP_DIV1;
      3'h2: div = `SCP_DIV2;
      3'h3: div = `SCP_DIV3;
      3'h4: div = `SCP_DIV4;
      3'h5: div = `SCP_DIV5;
      3'h6: div = `SCP_DIV6;
      default: div = `SCP_DIV7;
    endcase
  end
  wire tick = tick_cnt_q >= div - 12'h001;

  always @(posedge clk or posedge rst) begin
    if (rst) tick_cnt_q <= 12'h000;
    else tick_cnt_q <= tick ? 12'h000 : tick_cnt_q + 12'h001;
  end

  // ----------------------------------------------------------------
  // transmitter
  // ----------------------------------------------------------------
  wire [7:0] fifo_data;
  wire fifo_valid;
  wire tx_go = (flow == `SCP_FLOW_NONE) || (flow == `SCP_FLOW_HW && !cts_n) ||
    (flow == `SCP_FLOW_XON && !paused_q);
  wire tx_pop = tx_st_q == S_IDLE && tick && fifo_valid && tx_go;
  wire tx_end = tick && tx_sub_q == 4'hF;
  wire [7:0] tx_mask = data8 ? 8'hFF : 8'h7F;

  scp_fifo #(.W(8), .D(16), .AW(4)) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(wr && paddr == `SCP_OFS_TXD),
    .in_ready(fifo_in_ready),
    .in_data(pwdata[7:0]),
    .out_valid(fifo_valid),
    .out_ready(tx_pop),
    .out_data(fifo_data)
  );

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_st_q <= S_IDLE;
      tx_sub_q <= 4'h0;
      tx_bit_q <= 3'h0;
      tx_sh_q <= 8'h00;
      tx_par_q <= 1'b0;
      tx_stop2_q <= 1'b0;
      txd <= 1'b1;
    end else begin
      if (tick) tx_sub_q <= tx_sub_q + 4'h1;
      case (tx_st_q)
        S_IDLE: begin
          txd <= 1'b1;
          if (tx_pop) begin
            tx_st_q <= S_START;
            tx_sub_q <= 4'h0;
            tx_sh_q <= fifo_data & tx_mask;
            tx_par_q <= ^(fifo_data & tx_mask) ^ (par == `SCP_PAR_ODD);
            txd <= 1'b0;
          end
        end
        S_START: if (tx_end) begin
          tx_st_q <= S_DATA;
          tx_bit_q <= data8 ? 3'h7 : 3'h6;
          txd <= tx_sh_q[0];
          tx_sh_q <= {1'b0, tx_sh_q[7:1]};
        end
        S_DATA: if (tx_end) begin
          if (tx_bit_q != 3'h0) begin
            tx_bit_q <= tx_bit_q - 3'h1;
            txd <= tx_sh_q[0];
            tx_sh_q <= {1'b0, tx_sh_q[7:1]};
          end else if (par != `SCP_PAR_NONE) begin
            tx_st_q <= S_PAR;
            txd <= tx_par_q;
          end else begin
            tx_st_q <= S_STOP;
            tx_stop2_q <= act_q[`SCP_F_STOP2];
            txd <= 1'b1;
          end
        end
        S_PAR: if (tx_end) begin
          tx_st_q <= S_STOP;
          tx_stop2_q <= act_q[`SCP_F_STOP2];
          txd <= 1'b1;
        end
        S_STOP: if (tx_end) begin
          if (tx_stop2_q) tx_stop2_q <= 1'b0;
          else tx_st_q <= S_IDLE;
        end
        default: tx_st_q <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // receiver
  // ----------------------------------------------------------------
  // only the first stop bit is checked so a sender may use either count
  wire rx_samp = tick && rx_sub_q == 4'hF;
  wire [7:0] rx_byte = data8 ? rx_sh_q : {1'b0, rx_sh_q[7:1]};
  wire rx_done = rx_st_q == S_STOP && rx_samp;
  wire is_ctl = flow == `SCP_FLOW_XON && (rx_byte == `SCP_XOFF || rx_byte == `SCP_XON);
  wire rx_take = rd && paddr == `SCP_OFS_RXD;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_st_q <= S_IDLE;
      rx_sub_q <= 4'h0;
      rx_bit_q <= 3'h0;
      rx_sh_q <= 8'h00;
      rx_par_q <= 1'b0;
    end else begin
      if (tick) rx_sub_q <= rx_sub_q + 4'h1;
      case (rx_st_q)
        S_IDLE: if (tick && !rxd) begin
          rx_st_q <= S_START;
          rx_sub_q <= 4'h0;
        end
        S_START: if (tick && rx_sub_q == 4'h7) begin
          // recentre on mid-bit; a glitch returns to idle
          rx_sub_q <= 4'h0;
          rx_st_q <= rxd ? S_IDLE : S_DATA;
          rx_bit_q <= data8 ? 3'h7 : 3'h6;
          rx_par_q <= par == `SCP_PAR_ODD;
        end
        S_DATA: if (rx_samp) begin
          rx_sh_q <= {rxd, rx_sh_q[7:1]};
          rx_par_q <= rx_par_q ^ rxd;
          rx_bit_q <= rx_bit_q - 3'h1;
          if (rx_bit_q == 3'h0) rx_st_q <= par != `SCP_PAR_NONE ? S_PAR : S_STOP;
        end
        S_PAR: if (rx_samp) begin
          rx_par_q <= rx_par_q ^ rxd;
          rx_st_q <= S_STOP;
        end
        S_STOP: if (rx_samp) rx_st_q <= S_IDLE;
        default: rx_st_q <= S_IDLE;
      endcase
    end
  end

  // flags: a setting event wins over a clear in the same cycle
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_data_q <= 8'h00;
      rx_full_q <= 1'b0;
      par_err_q <= 1'b0;
      frm_err_q <= 1'b0;
      ovr_err_q <= 1'b0;
      paused_q <= 1'b0;
      rts_n <= 1'b0;
    end else begin
      rts_n <= flow == `SCP_FLOW_HW && rx_full_q;
      if (rx_done && !is_ctl) begin
        rx_data_q <= rx_byte;
        rx_full_q <= 1'b1;
      end else if (rx_take) begin
        rx_full_q <= 1'b0;
      end
      if (rx_done && rx_full_q && !rx_take && !is_ctl) ovr_err_q <= 1'b1;
      else if (clr) ovr_err_q <= 1'b0;
      if (rx_done && par != `SCP_PAR_NONE && rx_par_q) par_err_q <= 1'b1;
      else if (clr) par_err_q <= 1'b0;
      if (rx_done && !rxd) frm_err_q <= 1'b1;
      else if (clr) frm_err_q <= 1'b0;
      if (flow != `SCP_FLOW_XON) paused_q <= 1'b0;
      else if (rx_done && rx_byte == `SCP_XOFF) paused_q <= 1'b1;
      else if (rx_done && rx_byte == `SCP_XON) paused_q <= 1'b0;
    end
  end
endmodule

`default_nettype wire
